/* design/mdcrb_pkg.sv */
package mdcrb_pkg;
    // word layout on the serial link
    localparam int          WORD_BITS        = 16;
    localparam int          ADDR_BITS        = 5;
    localparam int          ADDR_MSB         = 15;
    localparam int          ADDR_LSB         = 11;
    localparam int          DATA_BITS        = 10;
    localparam int          CFG_COUNT        = 22;

    // register indices
    localparam logic [4:0]  ADDR_PWM_FREQ    = 5'h00;
    localparam logic [4:0]  ADDR_BASIC_TIME  = 5'h01;
    localparam logic [4:0]  ADDR_CFG_LAST    = 5'h15;
    localparam logic [4:0]  ADDR_NV_SAVE     = 5'h1C;
    localparam logic [4:0]  ADDR_FAULT_MASK  = 5'h1D;
    localparam logic [4:0]  ADDR_FAULT_FAULT_OUTPUT_PIN  = 5'h1E;
    localparam logic [4:0]  ADDR_RUN_CTRL    = 5'h1F;

    // field positions
    localparam int          CR_LSB           = 8;
    localparam int          PR_LSB           = 0;
    localparam int          DT_LSB           = 4;
    localparam int          SAVE_BIT         = 9;
    localparam int          MASK_MSB         = 9;
    localparam int          MASK_LSB         = 3;
    localparam int          CRIT_FAULT_BIT   = 15;
    localparam int          OVERWRITE_BIT    = 10;

    // reset values
    localparam logic [15:0] CFG_RESET        = 16'h0000;
    localparam logic [15:0] MASK_RESET       = 16'h0000;
    localparam logic [15:0] RUN_RESET        = 16'h0000;
    localparam logic [9:0]  COUNT_MAX        = 10'h3FF;

    // amplifier range in microvolts per code
    localparam logic [19:0] RANGE_UV_0       = 20'h7A120; // 500000
    localparam logic [19:0] RANGE_UV_1       = 20'h3D090; // 250000
    localparam logic [19:0] RANGE_UV_2       = 20'h1E848; // 125000
    localparam logic [19:0] RANGE_UV_3       = 20'h0F424; // 62500

    // pwm period in ns: base plus code times step
    localparam int          PWM_BASE_NS      = 30500;
    localparam int          PWM_STEP_NS      = 400;
    localparam int          DEAD_STEP_NS     = 50;
    localparam int          DEAD_MIN_NS      = 100;

    // clock and save duration
    localparam int          CLK_PERIOD_NS    = 50;
    localparam int          SAVE_TIME_MS     = 700;
    localparam int          SAVE_CYCLES      = SAVE_TIME_MS * (1000000 / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        SV_IDLE = 3'b001,
        SV_BUSY = 3'b010,
        SV_DONE = 3'b100
    } mdcrb_save_state_type;
endpackage : mdcrb_pkg

/* design/mdcrb_link_rx.sv */
`timescale 1ns/1ps
// shift register on the link clock; finished words cross by toggle plus held word
module mdcrb_link_rx (
    input  wire logic        i_clk_link,
    input  wire logic        i_resetn,
    input  wire logic        i_sdi,
    input  wire logic        i_frame,
    input  wire logic [15:0] i_tx_word,
    output logic      [15:0] o_word,
    output logic             o_toggle,
    output logic             o_sdo
);
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic [15:0] word_reg;
    logic [15:0] word_next;
    logic        tog_reg;
    logic        tog_next;
    logic [15:0] out_reg;
    logic [15:0] out_next;

    always_comb begin
        shift_next = shift_reg;
        cnt_next   = cnt_reg;
        word_next  = word_reg;
        tog_next   = tog_reg;
        out_next   = out_reg;
        if (!i_frame) begin
            cnt_next = 4'h0;
            out_next = i_tx_word;
        end else begin
            shift_next = {shift_reg[14:0], i_sdi};
            out_next   = {out_reg[14:0], 1'b0};
            cnt_next   = cnt_reg + 4'h1;
            if (cnt_reg == 4'hF) begin
                word_next = {shift_reg[14:0], i_sdi};
                tog_next  = ~tog_reg;
            end
        end
    end

    always_ff @(posedge i_clk_link or negedge i_resetn) begin
        if (!i_resetn) begin
            shift_reg <= 16'h0000;
            cnt_reg   <= 4'h0;
            word_reg  <= 16'h0000;
            tog_reg   <= 1'b0;
            out_reg   <= 16'h0000;
        end else begin
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
            word_reg  <= word_next;
            tog_reg   <= tog_next;
            out_reg   <= out_next;
        end
    end

    assign o_word   = word_reg;
    assign o_toggle = tog_reg;
    assign o_sdo    = out_reg[15];
endmodule : mdcrb_link_rx

/* design/mdcrb_top.sv */
`timescale 1ns/1ps
module mdcrb_top #(
    parameter int SAVE_CYCLES = mdcrb_pkg::SAVE_CYCLES
) (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RESETN,
    input  wire logic        I_CLK_LINK,
    input  wire logic        I_SDI,
    input  wire logic        I_FRAME,
    input  wire logic [9:3]  I_FAULT_FLAGS,
    input  wire logic        I_SAVE_FAIL,
    output logic             O_SDO,
    output logic             O_SDO_OE,
    output logic [1:0]       O_CURRENT_RANGE_SEL,
    output logic [19:0]      O_AMP_RANGE_UV,
    output logic [7:0]       O_PWM_PERIOD_CODE,
    output logic [17:0]      O_PWM_PERIOD_NS,
    output logic [5:0]       O_DEAD_TIME_CODE,
    output logic [11:0]      O_DEAD_TIME_NS,
    output logic             O_SAVE_BUSY,
    output logic [15:0]      O_RUN_CTRL,
    output logic             O_FAULT_OUTPUT_PIN
);
    function automatic logic [19:0] range_uv(input logic [1:0] sel);
        case (sel)
            2'h0:    range_uv = mdcrb_pkg::RANGE_UV_0;
            2'h1:    range_uv = mdcrb_pkg::RANGE_UV_1;
            2'h2:    range_uv = mdcrb_pkg::RANGE_UV_2;
            default: range_uv = mdcrb_pkg::RANGE_UV_3;
        endcase
    endfunction : range_uv

    function automatic logic [17:0] pwm_ns(input logic [7:0] code);
        pwm_ns = 18'(mdcrb_pkg::PWM_BASE_NS) + 18'(code) * 18'(mdcrb_pkg::PWM_STEP_NS);
    endfunction : pwm_ns

    function automatic logic [11:0] dead_ns(input logic [5:0] code);
        logic [11:0] raw;
        raw = 12'(code) * 12'(mdcrb_pkg::DEAD_STEP_NS);
        // codes 0 and 1 are below the usable floor, clamp to the minimum
        dead_ns = (raw < 12'(mdcrb_pkg::DEAD_MIN_NS)) ? 12'(mdcrb_pkg::DEAD_MIN_NS) : raw;
    endfunction : dead_ns

    logic [15:0] rx_word;
    logic        rx_toggle;
    logic        link_sdo;
    logic [15:0] tx_word_reg;

    mdcrb_link_rx u_link (
        .i_clk_link (I_CLK_LINK),
        .i_resetn   (I_RESETN),
        .i_sdi      (I_SDI),
        .i_frame    (I_FRAME),
        .i_tx_word  (tx_word_reg),
        .o_word     (rx_word),
        .o_toggle   (rx_toggle),
        .o_sdo      (link_sdo)
    );

    // toggle crossing in three stages, frame level crossing in two
    logic [2:0]  tog_sync_reg;
    logic [1:0]  frame_sync_reg;
    logic [1:0]  sdo_sync_reg;
    logic [9:3]  flt_s1_reg;
    logic [9:3]  flt_s2_reg;
    logic [1:0]  fail_sync_reg;

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tog_sync_reg   <= 3'h0;
            frame_sync_reg <= 2'h0;
            sdo_sync_reg   <= 2'h0;
            flt_s1_reg     <= 7'h00;
            flt_s2_reg     <= 7'h00;
            fail_sync_reg  <= 2'h0;
        end else begin
            tog_sync_reg   <= {tog_sync_reg[1:0], rx_toggle};
            frame_sync_reg <= {frame_sync_reg[0], I_FRAME};
            sdo_sync_reg   <= {sdo_sync_reg[0], link_sdo};
            flt_s1_reg     <= I_FAULT_FLAGS;
            flt_s2_reg     <= flt_s1_reg;
            fail_sync_reg  <= {fail_sync_reg[0], I_SAVE_FAIL};
        end
    end

    // word is stable in the link domain for a whole word time after the toggle
    wire         word_event = tog_sync_reg[2] ^ tog_sync_reg[1];
    wire  [4:0]  w_addr     = rx_word[mdcrb_pkg::ADDR_MSB:mdcrb_pkg::ADDR_LSB];
    wire  [9:0]  w_data     = rx_word[9:0];

    logic [15:0] cfg_reg  [mdcrb_pkg::CFG_COUNT];
    logic [15:0] cfg_next [mdcrb_pkg::CFG_COUNT];
    logic        save_bit_reg;
    logic        save_bit_next;
    logic [9:0]  count_reg;
    logic [9:0]  count_next;
    logic        ovw_reg;
    logic        ovw_next;
    logic        crit_reg;
    logic        crit_next;
    logic [15:0] mask_reg;
    logic [15:0] mask_next;
    logic [15:0] run_reg;
    logic [15:0] run_next;
    logic [9:3]  fault_output_pin_reg;
    logic [9:3]  fault_output_pin_next;
    logic [31:0] timer_reg;
    logic [31:0] timer_next;
    logic [15:0] tx_word_next;
    logic        fault_pin_reg;
    logic        fault_pin_next;
    mdcrb_pkg::mdcrb_save_state_type state_reg;
    mdcrb_pkg::mdcrb_save_state_type state_next;

    function automatic logic [15:0] read_word(input logic [4:0] a,
                                              input logic [15:0] cfg,
                                              input logic [9:0] cnt,
                                              input logic crit,
                                              input logic ovw,
                                              input logic [9:3] dg,
                                              input logic [15:0] msk,
                                              input logic [15:0] run);
        read_word = 16'h0000;
        case (a)
            mdcrb_pkg::ADDR_NV_SAVE: begin
                read_word[9:0] = cnt;
                read_word[mdcrb_pkg::CRIT_FAULT_BIT] = crit;
                read_word[mdcrb_pkg::OVERWRITE_BIT]  = ovw;
            end
            mdcrb_pkg::ADDR_FAULT_MASK: read_word[9:3] = msk[9:3];
            mdcrb_pkg::ADDR_FAULT_FAULT_OUTPUT_PIN: begin
                read_word[9:3] = dg;
                read_word[mdcrb_pkg::CRIT_FAULT_BIT] = crit;
                read_word[mdcrb_pkg::OVERWRITE_BIT]  = ovw;
            end
            mdcrb_pkg::ADDR_RUN_CTRL:   read_word[9:0] = run[9:0];
            default: begin
                if (a <= mdcrb_pkg::ADDR_CFG_LAST) begin
                    read_word = cfg;
                end
            end
        endcase
    endfunction : read_word

    always_comb begin
        cfg_next      = cfg_reg;
        save_bit_next = save_bit_reg;
        count_next    = count_reg;
        ovw_next      = ovw_reg;
        crit_next     = crit_reg;
        mask_next     = mask_reg;
        run_next      = run_reg;
        fault_output_pin_next     = fault_output_pin_reg | flt_s2_reg;
        timer_next    = timer_reg;
        state_next    = state_reg;
        tx_word_next  = tx_word_reg;
        if (word_event) begin
            tx_word_next = read_word(w_addr,
                                     cfg_reg[w_addr <= mdcrb_pkg::ADDR_CFG_LAST ? w_addr : 5'h00],
                                     count_reg, crit_reg, ovw_reg, fault_output_pin_reg, mask_reg, run_reg);
            if (w_addr == mdcrb_pkg::ADDR_NV_SAVE) begin
                save_bit_next = w_data[mdcrb_pkg::SAVE_BIT];
            end else if (state_reg == mdcrb_pkg::SV_IDLE) begin
                // run commands and config edits are ignored while saving
                if (w_addr <= mdcrb_pkg::ADDR_CFG_LAST) begin
                    cfg_next[w_addr] = {6'h00, w_data};
                end else if (w_addr == mdcrb_pkg::ADDR_FAULT_MASK) begin
                    mask_next = {6'h00, w_data[9:3], 3'h0};
                end else if (w_addr == mdcrb_pkg::ADDR_RUN_CTRL) begin
                    run_next = {6'h00, w_data};
                end
            end
        end
        case (state_reg)
            mdcrb_pkg::SV_IDLE: begin
                if (word_event && w_addr == mdcrb_pkg::ADDR_NV_SAVE && save_bit_reg
                    && !w_data[mdcrb_pkg::SAVE_BIT]) begin
                    state_next = mdcrb_pkg::SV_BUSY;
                    timer_next = 32'h0000_0000;
                end
            end
            mdcrb_pkg::SV_BUSY: begin
                timer_next = timer_reg + 32'h0000_0001;
                if (timer_reg >= 32'(SAVE_CYCLES - 1)) begin
                    state_next = mdcrb_pkg::SV_DONE;
                end
            end
            mdcrb_pkg::SV_DONE: begin
                state_next = mdcrb_pkg::SV_IDLE;
                if (fail_sync_reg[1]) begin
                    crit_next = 1'b1;
                end else begin
                    fault_output_pin_next = flt_s2_reg;
                    crit_next = 1'b0;
                    if (count_reg == mdcrb_pkg::COUNT_MAX) begin
                        ovw_next   = 1'b1;
                        count_next = ovw_reg ? mdcrb_pkg::COUNT_MAX : 10'h000;
                    end else begin
                        count_next = count_reg + 10'h001;
                    end
                end
            end
            default: state_next = mdcrb_pkg::SV_IDLE;
        endcase
        fault_pin_next = |(fault_output_pin_reg & ~mask_reg[mdcrb_pkg::MASK_MSB:mdcrb_pkg::MASK_LSB]) | crit_reg;
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            for (int i = 0; i < mdcrb_pkg::CFG_COUNT; i++) begin
                cfg_reg[i] <= mdcrb_pkg::CFG_RESET;
            end
            save_bit_reg  <= 1'b0;
            count_reg     <= 10'h000;
            ovw_reg       <= 1'b0;
            crit_reg      <= 1'b0;
            mask_reg      <= mdcrb_pkg::MASK_RESET;
            run_reg       <= mdcrb_pkg::RUN_RESET;
            fault_output_pin_reg      <= 7'h00;
            timer_reg     <= 32'h0000_0000;
            state_reg     <= mdcrb_pkg::SV_IDLE;
            tx_word_reg   <= 16'h0000;
            fault_pin_reg <= 1'b0;
        end else begin
            cfg_reg       <= cfg_next;
            save_bit_reg  <= save_bit_next;
            count_reg     <= count_next;
            ovw_reg       <= ovw_next;
            crit_reg      <= crit_next;
            mask_reg      <= mask_next;
            run_reg       <= run_next;
            fault_output_pin_reg      <= fault_output_pin_next;
            timer_reg     <= timer_next;
            state_reg     <= state_next;
            tx_word_reg   <= tx_word_next;
            fault_pin_reg <= fault_pin_next;
        end
    end

    // decoded field outputs, each registered
    logic [15:0] cfg0;
    logic [15:0] cfg1;
    assign cfg0 = cfg_reg[mdcrb_pkg::ADDR_PWM_FREQ];
    assign cfg1 = cfg_reg[mdcrb_pkg::ADDR_BASIC_TIME];

    logic [1:0]  sel_o_next;
    logic [19:0] amp_o_next;
    logic [7:0]  pcode_o_next;
    logic [17:0] pns_o_next;
    logic [5:0]  dcode_o_next;
    logic [11:0] dns_o_next;
    logic        busy_o_next;
    logic [15:0] run_o_next;
    logic        fpin_o_next;
    logic        sdo_o_next;
    logic        oe_o_next;

    always_comb begin
        sel_o_next   = cfg0[mdcrb_pkg::CR_LSB +: 2];
        amp_o_next   = range_uv(cfg0[mdcrb_pkg::CR_LSB +: 2]);
        pcode_o_next = cfg0[mdcrb_pkg::PR_LSB +: 8];
        pns_o_next   = pwm_ns(cfg0[mdcrb_pkg::PR_LSB +: 8]);
        dcode_o_next = cfg1[mdcrb_pkg::DT_LSB +: 6];
        dns_o_next   = dead_ns(cfg1[mdcrb_pkg::DT_LSB +: 6]);
        busy_o_next  = (state_reg != mdcrb_pkg::SV_IDLE);
        // motor is coasted while saving
        run_o_next   = busy_o_next ? 16'h0000 : run_reg;
        fpin_o_next  = fault_pin_reg;
        // sdo is re-timed to the system clock; a slow link keeps it usable
        sdo_o_next   = sdo_sync_reg[1];
        oe_o_next    = frame_sync_reg[1];
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_CURRENT_RANGE_SEL <= 2'h0;
            O_AMP_RANGE_UV      <= mdcrb_pkg::RANGE_UV_0;
            O_PWM_PERIOD_CODE   <= 8'h00;
            O_PWM_PERIOD_NS     <= 18'(mdcrb_pkg::PWM_BASE_NS);
            O_DEAD_TIME_CODE    <= 6'h00;
            O_DEAD_TIME_NS      <= 12'(mdcrb_pkg::DEAD_MIN_NS);
            O_SAVE_BUSY         <= 1'b0;
            O_RUN_CTRL          <= 16'h0000;
            O_FAULT_OUTPUT_PIN  <= 1'b0;
            O_SDO               <= 1'b0;
            O_SDO_OE            <= 1'b0;
        end else begin
            O_CURRENT_RANGE_SEL <= sel_o_next;
            O_AMP_RANGE_UV      <= amp_o_next;
            O_PWM_PERIOD_CODE   <= pcode_o_next;
            O_PWM_PERIOD_NS     <= pns_o_next;
            O_DEAD_TIME_CODE    <= dcode_o_next;
            O_DEAD_TIME_NS      <= dns_o_next;
            O_SAVE_BUSY         <= busy_o_next;
            O_RUN_CTRL          <= run_o_next;
            O_FAULT_OUTPUT_PIN  <= fpin_o_next;
            O_SDO               <= sdo_o_next;
            O_SDO_OE            <= oe_o_next;
        end
    end
endmodule : mdcrb_top

/* test/mdcrb_props.sv */
`timescale 1ns/1ps
module mdcrb_props #(
    parameter int SAVE_CYCLES = 20
) (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RESETN,
    input  wire logic        I_FRAME,
    input  wire logic [9:3]  I_FAULT_FLAGS,
    input  wire logic        I_SAVE_FAIL,
    input  wire logic        O_SDO_OE,
    input  wire logic [1:0]  O_CURRENT_RANGE_SEL,
    input  wire logic [19:0] O_AMP_RANGE_UV,
    input  wire logic [7:0]  O_PWM_PERIOD_CODE,
    input  wire logic [17:0] O_PWM_PERIOD_NS,
    input  wire logic [5:0]  O_DEAD_TIME_CODE,
    input  wire logic [11:0] O_DEAD_TIME_NS,
    input  wire logic        O_SAVE_BUSY,
    input  wire logic [15:0] O_RUN_CTRL,
    input  wire logic        O_FAULT_OUTPUT_PIN
);
    int busy_cnt_reg;
    int busy_cnt_next;

    // counts how long a save keeps the bank busy; a repetition would unroll too far
    always_comb begin
        busy_cnt_next = O_SAVE_BUSY ? busy_cnt_reg + 1 : 0;
    end
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            busy_cnt_reg <= 0;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
        end
    end

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESETN);

    sequence s_save_end;
        $fell(O_SAVE_BUSY);
    endsequence
    sequence s_clean_end;
        $fell(O_SAVE_BUSY) && I_FAULT_FLAGS == 7'h00 && !I_SAVE_FAIL;
    endsequence
    sequence s_fail_end;
        $fell(O_SAVE_BUSY) && I_SAVE_FAIL;
    endsequence

    a_range_decode: assert property ($stable(O_CURRENT_RANGE_SEL) |-> O_AMP_RANGE_UV ==
        (O_CURRENT_RANGE_SEL == 2'h0 ? 20'h7A120 : O_CURRENT_RANGE_SEL == 2'h1 ? 20'h3D090 :
         O_CURRENT_RANGE_SEL == 2'h2 ? 20'h1E848 : 20'h0F424)) else $error("amp range mismatch");
    a_pwm_period: assert property ($stable(O_PWM_PERIOD_CODE) |-> O_PWM_PERIOD_NS ==
        18'(mdcrb_pkg::PWM_BASE_NS + mdcrb_pkg::PWM_STEP_NS * O_PWM_PERIOD_CODE)) else $error("pwm period mismatch");
    a_dead_time: assert property ($stable(O_DEAD_TIME_CODE) |-> O_DEAD_TIME_NS ==
        (O_DEAD_TIME_CODE < 6'h02 ? 12'h064 : 12'(O_DEAD_TIME_CODE * 50))) else $error("dead time mismatch");
    a_dead_floor: assert property (O_DEAD_TIME_NS >= 12'h064) else $error("dead time below floor");
    a_busy_length: assert property (
        s_save_end |-> busy_cnt_reg >= SAVE_CYCLES && busy_cnt_reg <= SAVE_CYCLES + 2) else $error("save length off");
    a_busy_cap: assert property (busy_cnt_reg <= SAVE_CYCLES + 2) else $error("save runs too long");
    a_run_coast: assert property (
        O_SAVE_BUSY [*2] |-> O_RUN_CTRL == 16'h0000) else $error("run bits live during save");
    a_fault_clear: assert property (
        s_clean_end |-> ##[1:3] !O_FAULT_OUTPUT_PIN) else $error("fault pin not cleared by save");
    a_fail_crit: assert property (
        s_fail_end |-> ##[0:3] O_FAULT_OUTPUT_PIN) else $error("failed save left pin low");
    a_oe_follow: assert property ($rose(I_FRAME) |-> ##[1:6] O_SDO_OE) else $error("oe missed frame");
    a_oe_release: assert property ($fell(I_FRAME) |-> ##[1:6] !O_SDO_OE) else $error("oe held");
endmodule : mdcrb_props

bind mdcrb_top mdcrb_props #(.SAVE_CYCLES(SAVE_CYCLES)) u_mdcrb_props (
    .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_FRAME(I_FRAME), .I_FAULT_FLAGS(I_FAULT_FLAGS),
    .I_SAVE_FAIL(I_SAVE_FAIL), .O_SDO_OE(O_SDO_OE), .O_CURRENT_RANGE_SEL(O_CURRENT_RANGE_SEL),
    .O_AMP_RANGE_UV(O_AMP_RANGE_UV), .O_PWM_PERIOD_CODE(O_PWM_PERIOD_CODE), .O_PWM_PERIOD_NS(O_PWM_PERIOD_NS),
    .O_DEAD_TIME_CODE(O_DEAD_TIME_CODE), .O_DEAD_TIME_NS(O_DEAD_TIME_NS), .O_SAVE_BUSY(O_SAVE_BUSY),
    .O_RUN_CTRL(O_RUN_CTRL), .O_FAULT_OUTPUT_PIN(O_FAULT_OUTPUT_PIN));

/* test/mdcrb_host_model.sv */
`timescale 1ns/1ps
// host side of the serial link; its clock stands still between frames
module mdcrb_host_model (
    output logic        o_clk_link,
    output logic        o_sdi,
    output logic        o_frame,
    input  wire logic   i_sdo,
    output logic        o_rx_valid,
    output logic [15:0] o_rx_word
);
    initial begin
        o_clk_link = 1'b0;
        o_sdi      = 1'b0;
        o_frame    = 1'b0;
        o_rx_valid = 1'b0;
        o_rx_word  = 16'h0000;
    end

    // one link edge with no frame, so the link side sees reset
    task automatic pulse();
        #40;
        o_clk_link = 1'b1;
        #62.5;
        o_clk_link = 1'b0;
    endtask : pulse

    task automatic xfer(input logic [15:0] w, input logic rd);
        int i;
        #3;
        // one edge with the frame low loads the answer to the previous word
        o_clk_link = 1'b1;
        #62.5;
        o_clk_link = 1'b0;
        #31.25;
        o_frame = 1'b1;
        for (i = 15; i >= 0; i--) begin
            o_sdi = w[i];
            #31.25;
            o_clk_link = 1'b1;
            #62.5;
            // sdo lags about three system clocks, so it is taken at the falling edge
            o_rx_word = {o_rx_word[14:0], i_sdo};
            o_clk_link = 1'b0;
            #31.25;
        end
        o_frame = 1'b0;
        // released line shows the inverse, not the last bit
        o_sdi = ~w[0];
        if (rd) begin
            o_rx_valid = 1'b1;
            #10;
            o_rx_valid = 1'b0;
        end
        // gap keeps words well above eight system clocks apart
        #500;
    endtask : xfer
endmodule : mdcrb_host_model

/* test/mdcrb_test.sv */
`timescale 1ns/1ps
module mdcrb_test;
    localparam int SAVE_CYC = 80;
    logic        clk_sys;
    logic        resetn;
    logic        clk_link;
    logic        sdi;
    logic        frame;
    logic [9:3]  fault_flags;
    logic        save_fail;
    logic        rx_valid;
    logic [15:0] rx_word;
    logic        sdo;
    logic        sdo_oe;
    logic        busy;
    logic        fault_pin;
    logic [1:0]  range_sel;
    logic [19:0] amp_uv;
    logic [7:0]  pwm_code;
    logic [17:0] pwm_ns;
    logic [5:0]  dead_code;
    logic [11:0] dead_ns;
    logic [15:0] run_ctrl;
    logic [15:0] exp_q[$];
    logic [15:0] rng;
    logic [15:0] r;
    logic [7:0]  p;
    logic [19:0] uv_tab[4] = '{20'h7A120, 20'h3D090, 20'h1E848, 20'h0F424};
    // last code gives 3.15 us, inside the recommended span
    logic [5:0]  dt_tab[5] = '{6'h00, 6'h01, 6'h02, 6'h1E, 6'h3F};
    int          err_total;
    int          check_count;
    int          i;

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    mdcrb_top #(.SAVE_CYCLES(SAVE_CYC)) u_mdcrb_top (
        .I_CLK_SYS(clk_sys), .I_RESETN(resetn), .I_CLK_LINK(clk_link), .I_SDI(sdi), .I_FRAME(frame),
        .I_FAULT_FLAGS(fault_flags), .I_SAVE_FAIL(save_fail), .O_SDO(sdo), .O_SDO_OE(sdo_oe),
        .O_CURRENT_RANGE_SEL(range_sel), .O_AMP_RANGE_UV(amp_uv), .O_PWM_PERIOD_CODE(pwm_code),
        .O_PWM_PERIOD_NS(pwm_ns), .O_DEAD_TIME_CODE(dead_code), .O_DEAD_TIME_NS(dead_ns),
        .O_SAVE_BUSY(busy), .O_RUN_CTRL(run_ctrl), .O_FAULT_OUTPUT_PIN(fault_pin));

    mdcrb_host_model u_mdcrb_host_model (
        .o_clk_link(clk_link), .o_sdi(sdi), .o_frame(frame), .i_sdo(sdo),
        .o_rx_valid(rx_valid), .o_rx_word(rx_word));

    function automatic logic [15:0] xs();
        rng ^= rng << 7;
        rng ^= rng >> 9;
        rng ^= rng << 8;
        return rng;
    endfunction : xs

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    task automatic wr(input logic [4:0] a, input logic [9:0] d);
        u_mdcrb_host_model.xfer({a, 1'b0, d}, 1'b0);
        @(negedge clk_sys);
    endtask : wr

    // count register answers in the frame after the one that addresses it
    task automatic rd28(input logic [15:0] e);
        wr(mdcrb_pkg::ADDR_NV_SAVE, 10'h000);
        exp_q.push_back(e);
        u_mdcrb_host_model.xfer({mdcrb_pkg::ADDR_NV_SAVE, 11'h000}, 1'b1);
        @(negedge clk_sys);
    endtask : rd28

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 400) begin
            err_total++;
            summarize();
        end
    endtask : wait_busy

    task automatic do_save();
        wr(mdcrb_pkg::ADDR_NV_SAVE, 10'h200);
        wr(mdcrb_pkg::ADDR_NV_SAVE, 10'h000);
        wait_busy(1'b1);
        // run writes during a save must be dropped
        wr(mdcrb_pkg::ADDR_RUN_CTRL, 10'h111);
        wait_busy(1'b0);
        repeat (4) @(negedge clk_sys);
    endtask : do_save

    initial begin
        forever begin
            @(posedge rx_valid);
            if (exp_q.size() > 0) check(rx_word, exp_q.pop_front());
        end
    end

    initial begin
        #3000000;
        err_total++;
        summarize();
    end

    initial begin
        resetn = 1'b0;
        fault_flags = 7'h00;
        save_fail = 1'b0;
        err_total = 0;
        check_count = 0;
        rng = 16'h005F;
        fork
            u_mdcrb_host_model.pulse();
        join_none
        repeat (16) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        check(amp_uv, 20'h7A120);
        check(pwm_ns, 18'h07724);
        check(dead_ns, 12'h064);
        check({busy, fault_pin, range_sel, pwm_code, dead_code, run_ctrl}, 32'h0000_0000);
        for (i = 0; i < 8; i++) begin
            r = xs();
            p = (i == 7) ? 8'hFF : r[7:0];
            wr(mdcrb_pkg::ADDR_PWM_FREQ, {i[1:0], p});
            check(range_sel, i[1:0]);
            check(amp_uv, uv_tab[i[1:0]]);
            check(pwm_code, p);
            check(pwm_ns, 30500 + 400 * p);
        end
        for (i = 0; i < 5; i++) begin
            r = xs();
            wr(mdcrb_pkg::ADDR_BASIC_TIME, {dt_tab[i], r[3:0]});
            check(dead_code, dt_tab[i]);
            check(dead_ns, (dt_tab[i] < 6'h02) ? 100 : 50 * dt_tab[i]);
        end
        wr(mdcrb_pkg::ADDR_FAULT_MASK, 10'h020);
        fault_flags = 7'h04;
        repeat (6) @(negedge clk_sys);
        check(fault_pin, 1'b0);
        fault_flags = 7'h0C;
        repeat (6) @(negedge clk_sys);
        check(fault_pin, 1'b1);
        fault_flags = 7'h00;
        repeat (4) @(negedge clk_sys);
        check(fault_pin, 1'b1);
        wr(mdcrb_pkg::ADDR_RUN_CTRL, 10'h2A5);
        check(run_ctrl, 16'h02A5);
        rd28(16'h0000);
        do_save();
        check(fault_pin, 1'b0);
        check(run_ctrl, 16'h02A5);
        rd28(16'h0001);
        save_fail = 1'b1;
        do_save();
        save_fail = 1'b0;
        check(fault_pin, 1'b1);
        rd28(16'h8001);
        do_save();
        check(fault_pin, 1'b0);
        rd28(16'h0002);
        repeat (20) @(negedge clk_sys);
        check(exp_q.size(), 32'h0000_0000);
        summarize();
    end
endmodule : mdcrb_test
